// *** logic/sfcf_front_end.v ***
// Command front end of a multi-I/O serial NOR flash: framing, widths, addressing.
// Assumes mclk far above SCK (SCK period >= 8 mclk); array, status and config live outside, except the volatile address length bit.
`timescale 1ns/1ps
`include "sfcf_map.vh"
module sfcf_front_end (
  input  wire        mclk,
  input  wire        srst,
  input  wire        cs_n,
  input  wire        sck,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe,
  input  wire        all_quad_command_mode,
  input  wire        nonvolatile_config_two_addr_len,
  input  wire        soft_reset,
  input  wire        addr_len_wr,
  input  wire        addr_len_wdata,
  input  wire        embedded_op_active,
  input  wire [3:0]  dummy_cycles,
  input  wire [7:0]  rd_data,
  output reg         volatile_config_two_addr_len,
  output reg         cmd_start,
  output reg  [7:0]  cmd_opcode,
  output reg  [31:0] cmd_addr,
  output reg         addr_valid,
  output reg  [7:0]  mode_bits,
  output reg         cont_read_active,
  output reg         rd_take,
  output reg         wr_valid,
  output reg  [7:0]  wr_byte,
  output reg  [31:0] wr_addr,
  output reg         cmd_end,
  output reg         cmd_reject
);
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_INSTR = 8'h02;
  localparam [7:0] ST_ADDR  = 8'h04;
  localparam [7:0] ST_MODE  = 8'h08;
  localparam [7:0] ST_DUMMY = 8'h10;
  localparam [7:0] ST_RDATA = 8'h20;
  localparam [7:0] ST_WDATA = 8'h40;
  localparam [7:0] ST_SINK  = 8'h80;
  // Pack {addr kind, addr width, data width, mode, dummy, wr, rd, known}
  function [10:0] pk;
    input [1:0] ak, aw, dw;
    input       md, dm, wr, rd;
    begin
      pk = {ak, aw, dw, md, dm, wr, rd, 1'b1};
    end
  endfunction
  function [10:0] op_info;
    input [7:0] op;
    begin
      case (op)
        8'h03: op_info = pk(`SFCF_AK_LEG,  `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b0, 1'b1);
        8'h13: op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b0, 1'b1);
        8'h0B, 8'h4B, 8'h65, 8'h19, 8'hFA, 8'hFC:
          op_info = pk(`SFCF_AK_LEG, `SFCF_W1, `SFCF_W1, 1'b0, 1'b1, 1'b0, 1'b1);
        8'h0C, 8'h18, 8'hE0, 8'hE2:
          op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W1, 1'b0, 1'b1, 1'b0, 1'b1);
        8'h3B: op_info = pk(`SFCF_AK_LEG,  `SFCF_W1, `SFCF_W2, 1'b0, 1'b1, 1'b0, 1'b1);
        8'h3C: op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W2, 1'b0, 1'b1, 1'b0, 1'b1);
        8'h6B: op_info = pk(`SFCF_AK_LEG,  `SFCF_W1, `SFCF_W4, 1'b0, 1'b1, 1'b0, 1'b1);
        8'h6C: op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W4, 1'b0, 1'b1, 1'b0, 1'b1);
        8'hBB: op_info = pk(`SFCF_AK_LEG,  `SFCF_W2, `SFCF_W2, 1'b1, 1'b1, 1'b0, 1'b1);
        8'hBC: op_info = pk(`SFCF_AK_WIDE, `SFCF_W2, `SFCF_W2, 1'b1, 1'b1, 1'b0, 1'b1);
        8'hEB, 8'hED: op_info = pk(`SFCF_AK_LEG, `SFCF_W4, `SFCF_W4, 1'b1, 1'b1, 1'b0, 1'b1);
        8'hEC, 8'hEE: op_info = pk(`SFCF_AK_WIDE, `SFCF_W4, `SFCF_W4, 1'b1, 1'b1, 1'b0, 1'b1);
        8'h02, 8'h71, 8'h42, 8'hFB:
          op_info = pk(`SFCF_AK_LEG, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b1, 1'b0);
        8'h12, 8'hE1: op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b1, 1'b0);
        8'h32: op_info = pk(`SFCF_AK_LEG,  `SFCF_W1, `SFCF_W4, 1'b0, 1'b0, 1'b1, 1'b0);
        8'h34: op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W4, 1'b0, 1'b0, 1'b1, 1'b0);
        8'h20, 8'hD8, 8'hD0, 8'hFD:
          op_info = pk(`SFCF_AK_LEG, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b0, 1'b0);
        8'h21, 8'hDC, 8'hE3:
          op_info = pk(`SFCF_AK_WIDE, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b0, 1'b0);
        8'h05: op_info = pk(`SFCF_AK_NONE, `SFCF_W1, `SFCF_W1, 1'b0, 1'b0, 1'b0, 1'b1);
        default: op_info = 11'h000;
      endcase
    end
  endfunction
  function [5:0] lanes;
    input [1:0] w;
    begin
      case (w)
        `SFCF_W2: lanes = 6'h02;
        `SFCF_W4: lanes = 6'h04;
        default:  lanes = 6'h01;
      endcase
    end
  endfunction
  // Group LSB from IO0, groups MSB first; and
  function [31:0] shift_in;
    input [31:0] sh;
    input [3:0]  io;
    input [1:0]  w;
    begin
      case (w)
        `SFCF_W2: shift_in = {sh[29:0], io[1:0]};
        `SFCF_W4: shift_in = {sh[27:0], io[3:0]};
        default:  shift_in = {sh[30:0], io[0]};
      endcase
    end
  endfunction
  // Top bits of the byte go out first, MSB of group on the highest lane
  function [3:0] lane_bits;
    input [7:0] b;
    input [1:0] w;
    begin
      case (w)
        `SFCF_W2: lane_bits = {2'h0, b[7:6]};
        `SFCF_W4: lane_bits = b[7:4];
        default:  lane_bits = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction
  function [3:0] lane_oe;
    input [1:0] w;
    begin
      case (w)
        `SFCF_W2: lane_oe = 4'h3;
        `SFCF_W4: lane_oe = 4'hF;
        default:  lane_oe = 4'h2;
      endcase
    end
  endfunction
  // Pin synchronisers
  reg        cs_s1, cs_s2, cs_s3;
  reg        sck_s1, sck_s2, sck_s3;
  reg [3:0]  io_s1, io_s2;
  reg [7:0]  st_q;
  reg [10:0] info_q;
  reg [5:0]  bcnt_q;
  reg [5:0]  abits_q;
  reg [31:0] sh_q;
  reg [3:0]  dcnt_q;
  reg [7:0]  ob_q;
  reg [3:0]  obcnt_q;
  reg [7:0]  cont_op_q;
  reg        reload_q;
  wire       cs_rise  = cs_s2 & ~cs_s3;
  wire       cs_fall  = ~cs_s2 & cs_s3;
  wire       sck_rise = sck_s2 & ~sck_s3;
  wire       sck_fall = ~sck_s2 & sck_s3;
  reg [1:0]  cur_w;
  reg [31:0] sh_nxt;
  reg [5:0]  bcnt_nxt;
  reg [10:0] dec;
  reg [7:0]  rd_go;
  reg [7:0]  post_addr;
  reg [5:0]  n_out;
  always @*
  begin
    if (all_quad_command_mode)
      cur_w = `SFCF_W4;
    else if (st_q == ST_INSTR)
      cur_w = `SFCF_W1;
    else if (st_q == ST_ADDR || st_q == ST_MODE)
      cur_w = info_q[`SFCF_I_AW];
    else
      cur_w = info_q[`SFCF_I_DW];
    sh_nxt   = shift_in(sh_q, io_s2, cur_w);
    bcnt_nxt = bcnt_q + lanes(cur_w);
    n_out    = lanes(cur_w);
    dec      = op_info(sh_nxt[7:0]);
    if (embedded_op_active && sh_nxt[7:0] != `SFCF_OP_RDSTAT
        && sh_nxt[7:0] != `SFCF_OP_RDREG)
      dec = 11'h000;
    rd_go = (info_q[`SFCF_I_DUMMY] && dummy_cycles != 4'h0) ? ST_DUMMY : ST_RDATA;
    if (info_q[`SFCF_I_MODE])
      post_addr = ST_MODE;
    else if (info_q[`SFCF_I_RD])
      post_addr = rd_go;
    else if (info_q[`SFCF_I_WR])
      post_addr = ST_WDATA;
    else
      post_addr = ST_SINK;
  end
  always @(posedge mclk)
  begin
    if (srst)
    begin
      {cs_s3, cs_s2, cs_s1}    <= 3'h7;
      {sck_s3, sck_s2, sck_s1} <= 3'h0;
      {io_s2, io_s1}           <= 8'h00;
    end
    else
    begin
      {cs_s3, cs_s2, cs_s1}    <= {cs_s2, cs_s1, cs_n};
      {sck_s3, sck_s2, sck_s1} <= {sck_s2, sck_s1, sck};
      {io_s2, io_s1}           <= {io_s1, io_in};
    end
  end
  // Length bit reload one cycle after any reset
  always @(posedge mclk)
  begin
    if (srst)
    begin
      reload_q                     <= 1'b1;
      volatile_config_two_addr_len <= 1'b0;
    end
    else
    begin
      reload_q <= soft_reset;
      if (reload_q)
        volatile_config_two_addr_len <= nonvolatile_config_two_addr_len;
      else if (addr_len_wr)
        volatile_config_two_addr_len <= addr_len_wdata;
    end
  end
  always @(posedge mclk)
  begin
    if (srst)
    begin
      st_q             <= ST_IDLE;
      info_q           <= 11'h000;
      bcnt_q           <= 6'h00;
      abits_q          <= `SFCF_ABITS_S;
      sh_q             <= 32'h0000_0000;
      dcnt_q           <= 4'h0;
      ob_q             <= 8'h00;
      obcnt_q          <= 4'h0;
      cont_op_q        <= 8'h00;
      cont_read_active <= 1'b0;
      io_out           <= 4'h0;
      io_oe            <= 4'h0;
      cmd_start        <= 1'b0;
      cmd_opcode       <= 8'h00;
      cmd_addr         <= 32'h0000_0000;
      addr_valid       <= 1'b0;
      mode_bits        <= 8'h00;
      rd_take          <= 1'b0;
      wr_valid         <= 1'b0;
      wr_byte          <= 8'h00;
      wr_addr          <= 32'h0000_0000;
      cmd_end          <= 1'b0;
      cmd_reject       <= 1'b0;
    end
    else
    begin
      cmd_start  <= 1'b0;
      addr_valid <= 1'b0;
      rd_take    <= 1'b0;
      wr_valid   <= 1'b0;
      cmd_end    <= 1'b0;
      cmd_reject <= 1'b0;
      if (soft_reset)
        cont_read_active <= 1'b0;
      if (cs_rise)
      begin
        if (st_q != ST_IDLE)
        begin
          cmd_end    <= 1'b1;
          cmd_reject <= info_q[`SFCF_I_WR] && (bcnt_q[2:0] != 3'h0);
        end
        st_q  <= ST_IDLE;
        io_oe <= 4'h0;
      end
      else if (cs_fall)
      begin
        cmd_start <= 1'b1;
        bcnt_q    <= 6'h00;
        sh_q      <= 32'h0000_0000;
        obcnt_q   <= 4'h0;
        if (cont_read_active)
        begin
          st_q       <= ST_ADDR;
          cmd_opcode <= cont_op_q;
          info_q     <= embedded_op_active ? 11'h000 : op_info(cont_op_q);
        end
        else
          st_q <= ST_INSTR;
      end
      else if (!cs_s2 && sck_rise)
      begin
        sh_q   <= sh_nxt;
        bcnt_q <= bcnt_nxt;
        case (st_q)
          ST_INSTR:
          begin
            if (bcnt_nxt == `SFCF_BYTE_BITS)
            begin
              cmd_opcode <= sh_nxt[7:0];
              info_q     <= dec;
              bcnt_q     <= 6'h00;
              sh_q       <= 32'h0000_0000;
              cmd_addr   <= 32'h0000_0000;
              if (dec[`SFCF_I_AK] == `SFCF_AK_WIDE || volatile_config_two_addr_len)
                abits_q <= `SFCF_ABITS_L;
              else
                abits_q <= `SFCF_ABITS_S;
              if (!dec[`SFCF_I_KNOWN])
                st_q <= ST_SINK;
              else if (dec[`SFCF_I_AK] != `SFCF_AK_NONE)
                st_q <= ST_ADDR;
              else if (dec[`SFCF_I_RD])
                st_q <= ST_RDATA;
              else
                st_q <= ST_SINK;
            end
          end
          ST_ADDR:
          begin
            if (bcnt_nxt == abits_q)
            begin
              cmd_addr   <= sh_nxt;
              addr_valid <= 1'b1;
              bcnt_q     <= 6'h00;
              sh_q       <= 32'h0000_0000;
              dcnt_q     <= 4'h0;
              st_q       <= post_addr;
            end
          end
          ST_MODE:
          begin
            if (bcnt_nxt == `SFCF_BYTE_BITS)
            begin
              mode_bits        <= sh_nxt[7:0];
              cont_read_active <= (sh_nxt[7:4] == `SFCF_CONT_NIB);
              cont_op_q        <= cmd_opcode;
              bcnt_q           <= 6'h00;
              st_q             <= rd_go;
            end
          end
          ST_DUMMY:
          begin
            dcnt_q <= dcnt_q + 4'h1;
            if (dcnt_q + 4'h1 == dummy_cycles)
              st_q <= ST_RDATA;
          end
          ST_WDATA:
          begin
            if (bcnt_nxt == `SFCF_BYTE_BITS)
            begin
              wr_valid <= 1'b1;
              wr_byte  <= sh_nxt[7:0];
              wr_addr  <= cmd_addr;
              cmd_addr <= cmd_addr + 32'h0000_0001;
              bcnt_q   <= 6'h00;
            end
          end
          ST_RDATA, ST_SINK, ST_IDLE: bcnt_q <= bcnt_q;
          default: st_q <= ST_IDLE;
        endcase
      end
      else if (!cs_s2 && sck_fall && st_q == ST_RDATA)
      begin
        io_oe <= lane_oe(cur_w);
        if (obcnt_q == 4'h0)
        begin
          io_out   <= lane_bits(rd_data, cur_w);
          ob_q     <= rd_data << n_out[2:0];
          obcnt_q  <= 4'h8 - n_out[3:0];
          rd_take  <= 1'b1;
          cmd_addr <= cmd_addr + 32'h0000_0001;
        end
        else
        begin
          io_out  <= lane_bits(ob_q, cur_w);
          ob_q    <= ob_q << n_out[2:0];
          obcnt_q <= obcnt_q - n_out[3:0];
        end
      end
    end
  end
endmodule // sfcf_front_end

// *** logic/sfcf_map.vh ***
// Constants for the multi-I/O serial flash command front end.
// Assumes one includer; mode 0/3 link where the host samples on SCK rise.
// Notes on behaviour
// - Outside continuous read, every command opens with an eight-bit instruction byte.
// - Single-bit commands take everything on IO0 and return read data on IO1.
// - Dual/quad output reads take address on IO0, return data on 2 or 4 lines.
// - Dual/quad I/O commands take address and mode, return data, on 2 or 4 lines.
// - All-quad command mode carries every phase four bits per clock.
// - Otherwise the instruction alone sets the width of each later phase.
// - I/O reads carry mode bits after the address; a continue value implies next instruction.
// - In continuous read a command starts with address then mode bits, reusing the instruction.
// - Address is byte aligned, 24 or 32 bits, chosen by opcode or length bit.
// - Within a dual or quad group the least significant bit rides on IO0.
// - Bits and bit groups shift most significant first in both directions.
// - Address bytes arrive MSB first; data bytes go from rising byte addresses.
// - Reads allow zero or more dummy clocks before read data is driven.
// - During an embedded operation array reads are ignored; only few commands accepted.
// - A status read command lets the host see completion and success.
// - Host drives select, clock, IO0 single-bit; lines alternate in dual and quad.
// - Select falls before the first SCK rise, stays low; its rise ends the command.
// - Some commands are rejected when select rises off an eight-bit boundary.
// - Dedicated wide opcodes always take a 32-bit address.
// - Length bit reloads from nonvolatile copy at resets; when set, legacy opcodes use 32 bits.
// - The length bit governs the legacy opcode set.
`ifndef SFCF_MAP_VH
`define SFCF_MAP_VH
// Lane width codes
`define SFCF_W1        2'h0
`define SFCF_W2        2'h1
`define SFCF_W4        2'h2
// Decoded instruction info fields
`define SFCF_I_KNOWN   0
`define SFCF_I_RD      1
`define SFCF_I_WR      2
`define SFCF_I_DUMMY   3
`define SFCF_I_MODE    4
`define SFCF_I_DW      6:5
`define SFCF_I_AW      8:7
`define SFCF_I_AK      10:9
`define SFCF_INFO_W    11
// Address kinds
`define SFCF_AK_NONE   2'h0
`define SFCF_AK_LEG    2'h1
`define SFCF_AK_WIDE   2'h2
// Address and byte lengths in bits
`define SFCF_ABITS_S   6'h18
`define SFCF_ABITS_L   6'h20
`define SFCF_BYTE_BITS 6'h08
// Mode nibble that asks for continuous read
`define SFCF_CONT_NIB  4'hA
// Commands accepted while an embedded operation runs
`define SFCF_OP_RDSTAT 8'h05
`define SFCF_OP_RDREG  8'h65
`endif

// *** verif/sfcf_front_end_asserts.sv ***
// Port-level assertions for the serial flash command front end.
// Assumes SCK is slow against mclk and the host keeps select high between commands.
`timescale 1ns/1ps
module sfcf_front_end_chk (
  input logic       mclk,
  input logic       srst,
  input logic       cs_n,
  input logic [3:0] io_oe,
  input logic       all_quad_command_mode,
  input logic       embedded_op_active,
  input logic       soft_reset,
  input logic       nonvolatile_config_two_addr_len,
  input logic       volatile_config_two_addr_len,
  input logic [7:0] cmd_opcode,
  input logic       cmd_start,
  input logic       cmd_end,
  input logic       cmd_reject,
  input logic       cont_read_active
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_driving(op);
    !cs_n && io_oe != 4'h0 && !all_quad_command_mode && cmd_opcode == op;
  endsequence
  sequence s_reload;
    soft_reset ##1 !soft_reset;
  endsequence
  a_oe_released: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_start_on_select: assert property ($fell(cs_n) |-> ##[1:4] cmd_start)
    else $error("no start after select fell");
  a_end_on_release: assert property ($rose(cs_n) |-> ##[1:5] cmd_end)
    else $error("no end after select rose");
  a_reject_with_end: assert property (cmd_reject |-> cmd_end)
    else $error("reject without end");
  a_single_lane: assert property (s_driving(8'h03) or s_driving(8'h13) |-> io_oe == 4'h2)
    else $error("single read not on IO1 alone");
  a_quad_lanes: assert property (s_driving(8'heb) |-> io_oe == 4'hf)
    else $error("quad read not on four lanes");
  a_busy_silent: assert property (embedded_op_active && cmd_opcode == 8'h03 |-> io_oe == 4'h0)
    else $error("array read answered while busy");
  a_unknown_silent: assert property (!cs_n && cmd_opcode == 8'h00 |-> io_oe == 4'h0)
    else $error("unknown instruction drove lanes");
  a_len_reload: assert property (s_reload |-> ##[0:2] volatile_config_two_addr_len == nonvolatile_config_two_addr_len)
    else $error("length bit not reloaded");
  a_cont_cleared: assert property (s_reload |-> ##[0:2] !cont_read_active)
    else $error("continuous read kept over reset");
endmodule // sfcf_front_end_chk
bind sfcf_front_end sfcf_front_end_chk u_chk (
  .mclk(mclk), .srst(srst), .cs_n(cs_n), .io_oe(io_oe),
  .all_quad_command_mode(all_quad_command_mode), .embedded_op_active(embedded_op_active),
  .soft_reset(soft_reset), .nonvolatile_config_two_addr_len(nonvolatile_config_two_addr_len),
  .volatile_config_two_addr_len(volatile_config_two_addr_len), .cmd_opcode(cmd_opcode),
  .cmd_start(cmd_start), .cmd_end(cmd_end), .cmd_reject(cmd_reject),
  .cont_read_active(cont_read_active)
);

// *** verif/sfcf_host_model.sv ***
// Host controller model: drives select, SCK and the IO lanes, SPI mode 0.
// Assumes SCK half period of 24 ns; callers run one command at a time.
`timescale 1ns/1ps
module sfcf_host_model (
  input  logic       mclk,
  input  logic [3:0] io_out,
  input  logic [3:0] io_oe,
  output logic       cs_n,
  output logic       sck,
  output logic [3:0] io_in
);
  logic [3:0] h_io = 4'h0;
  logic [3:0] h_oe = 4'h0;
  logic [3:0] noise = 4'h5;
  initial cs_n = 1'b1;
  initial sck = 1'b0;
  always @(posedge mclk) noise <= ~noise;
  // Lanes nobody drives toggle so a stale value never passes
  assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_io) | (~io_oe & ~h_oe & noise);
  task automatic open_cmd();
    cs_n = 1'b0;
    #24;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w)
    begin
      h_oe = 4'((1 << w) - 1);
      h_io = 4'((v >> i) & ((1 << w) - 1));
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask
  task automatic recv(output logic [31:0] v, input int n, input int w);
    v = 32'h0000_0000;
    h_oe = 4'h0;
    for (int i = 0; i < n; i += w)
    begin
      #24 sck = 1'b1;
      v = (v << w) | 32'(w == 1 ? io_in[1] : io_in & 4'((1 << w) - 1));
      #24 sck = 1'b0;
    end
  endtask
  task automatic close_cmd();
    #24 cs_n = 1'b1;
    h_oe = 4'h0;
    #48;
  endtask
endmodule // sfcf_host_model

// *** verif/tb_multi_io_serial_flash_command_front_end.sv ***
// Self-checking bench for the serial flash command front end.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_multi_io_serial_flash_command_front_end;
  logic        mclk, srst, cs_n, sck, soft_reset, addr_len_wr, addr_len_wdata;
  logic        all_quad_command_mode, nonvolatile_config_two_addr_len, embedded_op_active;
  logic        volatile_config_two_addr_len, cmd_start, addr_valid, cont_read_active;
  logic        rd_take, wr_valid, cmd_end, cmd_reject;
  logic [3:0]  io_in, io_out, io_oe, dummy_cycles;
  logic [7:0]  cmd_opcode, mode_bits, wr_byte, key, mode_v;
  logic [7:0]  rd_data = 8'h00;
  logic [31:0] cmd_addr, wr_addr, rng, got, a;
  logic [31:0] exp_addr[$], exp_wr[$], exp_rej[$];
  int          errors, total_checks;
  bit          drove;
  sfcf_front_end dut (
    .mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .all_quad_command_mode(all_quad_command_mode),
    .nonvolatile_config_two_addr_len(nonvolatile_config_two_addr_len),
    .soft_reset(soft_reset), .addr_len_wr(addr_len_wr), .addr_len_wdata(addr_len_wdata),
    .embedded_op_active(embedded_op_active), .dummy_cycles(dummy_cycles), .rd_data(rd_data),
    .volatile_config_two_addr_len(volatile_config_two_addr_len), .cmd_start(cmd_start),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .addr_valid(addr_valid),
    .mode_bits(mode_bits), .cont_read_active(cont_read_active), .rd_take(rd_take),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_addr(wr_addr), .cmd_end(cmd_end),
    .cmd_reject(cmd_reject)
  );
  sfcf_host_model host (
    .mclk(mclk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sck(sck), .io_in(io_in)
  );
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] next_rng(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Array byte at each address is keyed so address steps show in the data
  always @(posedge mclk) rd_data <= cmd_addr[7:0] ^ key;
  always @(posedge mclk)
  begin
    if (!srst && io_oe !== 4'h0)
      drove = 1'b1;
    if (addr_valid === 1'b1)
      check(cmd_addr, exp_addr.pop_front());
    if (wr_valid === 1'b1)
      check({24'h0, wr_byte}, exp_wr.pop_front());
    if (cmd_end === 1'b1)
      check({31'h0, cmd_reject}, exp_rej.pop_front());
  end
  task automatic read_cmd(input bit inst, input logic [7:0] op, input logic [31:0] ad,
                          input int an, input int w, input bit md, input int nb);
    host.open_cmd();
    if (inst)
      host.send({24'h0, op}, 8, all_quad_command_mode ? 4 : 1);
    exp_addr.push_back(ad);
    host.send(ad, an, w);
    if (md)
      host.send({24'h0, mode_v}, 8, w);
    if (md)
      host.recv(got, int'(dummy_cycles) * w, w);
    for (int k = 0; k < nb; k++)
    begin
      host.recv(got, 8, w);
      check(got, {24'h0, 8'(ad + 32'(k)) ^ key});
    end
    exp_rej.push_back(32'h0);
    host.close_cmd();
  endtask
  task automatic silent_cmd(input logic [7:0] op);
    drove = 1'b0;
    host.open_cmd();
    host.send({24'h0, op}, 8, 1);
    host.send(rng, 24, 1);
    host.recv(got, 16, 1);
    exp_rej.push_back(32'h0);
    host.close_cmd();
    check({31'h0, drove}, 32'h0);
  endtask
  initial
  begin
    errors = 0;
    total_checks = 0;
    rng = 32'h8c3c;
    srst <= 1'b1;
    all_quad_command_mode <= 1'b0;
    nonvolatile_config_two_addr_len <= 1'b0;
    soft_reset <= 1'b0;
    addr_len_wr <= 1'b0;
    addr_len_wdata <= 1'b0;
    embedded_op_active <= 1'b0;
    dummy_cycles <= 4'h0;
    key <= 8'h00;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    rng = next_rng(rng);
    key <= rng[7:0];
    read_cmd(1'b1, 8'h03, {12'h0, rng[27:8]}, 24, 1, 1'b0, 3);
    $display("test single read done");
    rng = next_rng(rng);
    read_cmd(1'b1, 8'h13, {1'b0, rng[30:0]}, 32, 1, 1'b0, 2);
    $display("test wide opcode done");
    @(posedge mclk) nonvolatile_config_two_addr_len <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check({31'h0, volatile_config_two_addr_len}, 32'h1);
    rng = next_rng(rng);
    read_cmd(1'b1, 8'h03, {1'b0, rng[30:0]}, 32, 1, 1'b0, 2);
    @(posedge mclk) addr_len_wr <= 1'b1;
    @(posedge mclk) addr_len_wr <= 1'b0;
    repeat (3) @(posedge mclk);
    check({31'h0, volatile_config_two_addr_len}, 32'h0);
    $display("test address length done");
    rng = next_rng(rng);
    a = {12'h0, rng[19:0]};
    host.open_cmd();
    host.send(32'h02, 8, 1);
    exp_addr.push_back(a);
    host.send(a, 24, 1);
    for (int k = 0; k < 2; k++)
    begin
      rng = next_rng(rng);
      exp_wr.push_back({24'h0, rng[7:0]});
      host.send(rng, 8, 1);
    end
    host.send(32'h5, 3, 1);
    exp_rej.push_back(32'h1);
    host.close_cmd();
    $display("test write and partial byte done");
    @(posedge mclk) embedded_op_active <= 1'b1;
    silent_cmd(8'h03);
    host.open_cmd();
    host.send(32'h05, 8, 1);
    host.recv(got, 8, 1);
    exp_rej.push_back(32'h0);
    host.close_cmd();
    check(got, {24'h0, key});
    @(posedge mclk) embedded_op_active <= 1'b0;
    silent_cmd(8'h00);
    $display("test busy and unknown done");
    rng = next_rng(rng);
    @(posedge mclk) dummy_cycles <= 4'(1 + rng[1:0]);
    mode_v = 8'ha5;
    read_cmd(1'b1, 8'heb, {12'h0, rng[27:8]}, 24, 4, 1'b1, 2);
    check({31'h0, cont_read_active}, 32'h1);
    mode_v = 8'h00;
    rng = next_rng(rng);
    read_cmd(1'b0, 8'h00, {12'h0, rng[27:8]}, 24, 4, 1'b1, 2);
    check({24'h0, cmd_opcode}, 32'heb);
    check({31'h0, cont_read_active}, 32'h0);
    $display("test continuous read done");
    mode_v = 8'ha5;
    rng = next_rng(rng);
    read_cmd(1'b1, 8'hbb, {12'h0, rng[27:8]}, 24, 2, 1'b1, 1);
    check({31'h0, cont_read_active}, 32'h1);
    @(posedge mclk) soft_reset <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check({31'h0, cont_read_active}, 32'h0);
    check({31'h0, volatile_config_two_addr_len}, 32'h1);
    $display("test dual io and soft reset done");
    @(posedge mclk) all_quad_command_mode <= 1'b1;
    rng = next_rng(rng);
    read_cmd(1'b1, 8'h03, {1'b0, rng[30:0]}, 32, 4, 1'b0, 2);
    @(posedge mclk) all_quad_command_mode <= 1'b0;
    $display("test all quad done");
    repeat (10) @(posedge mclk);
    errors += exp_addr.size() + exp_wr.size() + exp_rej.size();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule // tb_multi_io_serial_flash_command_front_end
